// *** src/cvrm_vregion.sv ***
`timescale 1ns/1ps
// Overview of operation
// (R01) Second pattern group allowed on sensor-gate line
// (R02) Sensor-gate line starts with region's sequence group
// (R03) Second group select and start from field
// (R04) Special insert enable gates one extra line
// (R05) Special insert line is 12 bits
// (R06) Special select 5 bits, start 13 bits
// (R07) Software keeps special insert off gate line
// (R08) Software never mixes special insert and group B
// (R09) Sweep region ignores line boundaries until end
// (R10) Otherwise pulse train cut at line end
// (R11) Sweep enabled per region by its bit
// (R12) Pulse repeated by pattern repeat count
// (R13) Normal line-bounded operation resumes after sweep
// (R14) Software spaces regions so sweep finishes first
// (R15) Any region may be a multiplier region
// (R16) Multiplier keeps polarity, scales toggles by length
// (R17) Six toggles, counted from pattern start
// (R18) Multiplier enabled per region by its bit
// (R19) Software sets repeat count to highest toggle
// (R20) Second group start is 13 bits
// (R21) Line and pixel compares trigger special insert
module cvrm_vregion (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Line sync and field start come from on-chip counters on mclk_i
  input wire logic horizontal_line_sync_i,
  input wire logic field_start_i,
  input wire logic [cvrm_pkg::NUM_REG-1:0][cvrm_pkg::LINE_W-1:0] region_change_line_i,
  input wire logic [cvrm_pkg::NUM_REG-1:0] region_sweep_i,
  input wire logic [cvrm_pkg::NUM_REG-1:0] region_multi_i,
  input wire logic [cvrm_pkg::NUM_REG-1:0][cvrm_pkg::SEL_W-1:0] region_sequence_select_i,
  input wire logic [cvrm_pkg::LINE_W-1:0] sensor_gate_line_i,
  input wire logic [cvrm_pkg::SEL_W-1:0] second_group_select_i,
  input wire logic [cvrm_pkg::PIX_W-1:0] second_group_start_i,
  // Parameters of the sequence named by sequence_select_o
  input wire logic [cvrm_pkg::SEL_W-1:0] sequence_group_i,
  input wire logic [cvrm_pkg::REP_W-1:0] pattern_repeat_count_i,
  input wire logic special_insert_enable_i,
  input wire logic [cvrm_pkg::LINE_W-1:0] special_insert_line_i,
  input wire logic [cvrm_pkg::SEL_W-1:0] special_pattern_select_i,
  input wire logic [cvrm_pkg::PIX_W-1:0] special_pattern_start_i,
  // Definition of the group named by pattern_select_o
  input wire logic [cvrm_pkg::NUM_XV-1:0] pattern_polarity_i,
  input wire logic [cvrm_pkg::NUM_XV-1:0][cvrm_pkg::NUM_TOG-1:0][cvrm_pkg::PIX_W-1:0]
    vertical_toggle_position_i,
  input wire logic [cvrm_pkg::PIX_W-1:0] pattern_counter_length_i,
  output logic [cvrm_pkg::SEL_W-1:0] sequence_select_o,
  output logic [cvrm_pkg::SEL_W-1:0] pattern_select_o,
  output logic [cvrm_pkg::NUM_XV-1:0] vertical_transfer_outputs_o,
  output logic [cvrm_pkg::REG_W-1:0] region_o,
  output logic sensor_gate_line_o,
  output logic train_active_o
);

  function automatic logic tog_hit(
    input logic [cvrm_pkg::PIX_W-1:0] pos,
    input logic [cvrm_pkg::NUM_TOG-1:0][cvrm_pkg::PIX_W-1:0] togs
  );
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < cvrm_pkg::NUM_TOG; k++)
    begin
      if (togs[k] == pos)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : tog_hit

  logic [cvrm_pkg::LINE_W-1:0] line_r, line_nxt;
  logic [cvrm_pkg::LINE_W-1:0] lseq_r, lseq_nxt;
  logic [cvrm_pkg::REG_W-1:0] reg_r, reg_nxt;
  logic [cvrm_pkg::PIX_W-1:0] pix_r, pix_nxt;
  cvrm_pkg::cvrm_eng_t eng_r, eng_nxt;
  logic [cvrm_pkg::SEL_W-1:0] grp_r, grp_nxt;
  logic [cvrm_pkg::PIX_W-1:0] pos_r, pos_nxt;
  logic [cvrm_pkg::PIX_W-1:0] sub_r, sub_nxt;
  logic [cvrm_pkg::REP_W-1:0] rep_r, rep_nxt;
  logic [cvrm_pkg::NUM_XV-1:0] xv_r, xv_nxt;
  logic mult_r, mult_nxt;
  logic [cvrm_pkg::NUM_XV-1:0] hit_vec;
  logic [cvrm_pkg::PIX_W-1:0] len_m1;
  logic on_sg_line;
  logic sg_hit;
  logic sp_hit;
  logic line_start;
  logic sweep_keep;
  logic start_any;
  logic tick;

  // Toggle match per channel at the current pattern position
  genvar gc;
  generate
    for (gc = 0; gc < cvrm_pkg::NUM_XV; gc++)
    begin : g_hit
      assign hit_vec[gc] = tog_hit(pos_r, vertical_toggle_position_i[gc]); // R17
    end
  endgenerate

  // A length of zero is treated as one pixel
  assign len_m1 = (pattern_counter_length_i == cvrm_pkg::PIX_ZERO) ? cvrm_pkg::PIX_ZERO :
                  pattern_counter_length_i - cvrm_pkg::PIX_STEP;
  assign on_sg_line = (line_r == sensor_gate_line_i);
  assign sg_hit = on_sg_line && (pix_r == second_group_start_i); // R01 R03 R20
  assign sp_hit = special_insert_enable_i && (lseq_r == special_insert_line_i) &&
                  (pix_r == special_pattern_start_i); // R04 R05 R06 R21
  assign tick = (sub_r == cvrm_pkg::PIX_ZERO);

  // Line and region tracking
  always_comb
  begin
    line_nxt = line_r;
    lseq_nxt = lseq_r;
    reg_nxt = reg_r;
    pix_nxt = pix_r + cvrm_pkg::PIX_STEP;
    if (field_start_i)
    begin
      line_nxt = cvrm_pkg::LINE_ZERO;
      lseq_nxt = cvrm_pkg::LINE_ZERO;
      reg_nxt = cvrm_pkg::REG_FIRST;
      pix_nxt = cvrm_pkg::PIX_ZERO;
    end
    else if (horizontal_line_sync_i)
    begin
      line_nxt = line_r + cvrm_pkg::LINE_STEP;
      lseq_nxt = lseq_r + cvrm_pkg::LINE_STEP;
      pix_nxt = cvrm_pkg::PIX_ZERO;
      if ((reg_r != cvrm_pkg::REG_LAST) &&
          (line_nxt == region_change_line_i[reg_r + cvrm_pkg::REG_STEP]))
      begin
        reg_nxt = reg_r + cvrm_pkg::REG_STEP;
        lseq_nxt = cvrm_pkg::LINE_ZERO;
      end
    end
  end

  // A line start restarts the train unless a running sweep region continues
  assign sweep_keep = region_sweep_i[reg_nxt] && (lseq_nxt != cvrm_pkg::LINE_ZERO); // R09 R11
  assign line_start = field_start_i || (horizontal_line_sync_i && !sweep_keep); // R10 R13
  assign start_any = line_start || sg_hit || sp_hit;

  // Pattern engine
  always_comb
  begin
    eng_nxt = eng_r;
    grp_nxt = grp_r;
    pos_nxt = pos_r;
    sub_nxt = sub_r;
    rep_nxt = rep_r;
    xv_nxt = xv_r;
    mult_nxt = mult_r;
    if (line_start)
    begin
      // First group of the line comes from the region's sequence
      grp_nxt = sequence_group_i; // R02
      mult_nxt = region_multi_i[reg_nxt]; // R15 R18
      eng_nxt = cvrm_pkg::ENG_LOAD;
    end
    else if (sg_hit)
    begin
      grp_nxt = second_group_select_i; // R01 R03
      eng_nxt = cvrm_pkg::ENG_LOAD;
    end
    else if (sp_hit)
    begin
      grp_nxt = special_pattern_select_i; // R04 R06 R21
      eng_nxt = cvrm_pkg::ENG_LOAD;
    end
    else
    begin
      case (eng_r)
        cvrm_pkg::ENG_LOAD:
        begin
          xv_nxt = pattern_polarity_i; // R16
          pos_nxt = cvrm_pkg::PIX_ZERO;
          sub_nxt = cvrm_pkg::PIX_ZERO;
          rep_nxt = cvrm_pkg::REP_ZERO;
          eng_nxt = (pattern_repeat_count_i == cvrm_pkg::REP_ZERO) ? cvrm_pkg::ENG_IDLE :
                    cvrm_pkg::ENG_RUN;
        end
        cvrm_pkg::ENG_RUN:
        begin
          if (tick)
          begin
            xv_nxt = xv_r ^ hit_vec; // R17
          end
          if (mult_r)
          begin
            // Position advances once per counter length
            if (sub_r == len_m1)
            begin
              sub_nxt = cvrm_pkg::PIX_ZERO;
              pos_nxt = pos_r + cvrm_pkg::PIX_STEP; // R16
            end
            else
            begin
              sub_nxt = sub_r + cvrm_pkg::PIX_STEP;
            end
            if (tick && (pos_r[cvrm_pkg::REP_W-1:0] == pattern_repeat_count_i) &&
                (pos_r[cvrm_pkg::PIX_W-1] == 1'b0))
            begin
              eng_nxt = cvrm_pkg::ENG_IDLE;
            end
          end
          else if (pos_r == len_m1)
          begin
            // One pulse done; repeat until the count is used up
            pos_nxt = cvrm_pkg::PIX_ZERO;
            rep_nxt = rep_r + cvrm_pkg::REP_STEP; // R12
            if (rep_nxt == pattern_repeat_count_i)
            begin
              eng_nxt = cvrm_pkg::ENG_IDLE; // R12
            end
          end
          else
          begin
            pos_nxt = pos_r + cvrm_pkg::PIX_STEP;
          end
        end
        default:
        begin
          eng_nxt = cvrm_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      line_r <= cvrm_pkg::LINE_ZERO;
      lseq_r <= cvrm_pkg::LINE_ZERO;
      reg_r <= cvrm_pkg::REG_FIRST;
      pix_r <= cvrm_pkg::PIX_ZERO;
      eng_r <= cvrm_pkg::ENG_IDLE;
      grp_r <= cvrm_pkg::SEL_ZERO;
      pos_r <= cvrm_pkg::PIX_ZERO;
      sub_r <= cvrm_pkg::PIX_ZERO;
      rep_r <= cvrm_pkg::REP_ZERO;
      xv_r <= cvrm_pkg::XV_ZERO;
      mult_r <= 1'b0;
    end
    else if (ce_i)
    begin
      line_r <= line_nxt;
      lseq_r <= lseq_nxt;
      reg_r <= reg_nxt;
      pix_r <= pix_nxt;
      eng_r <= eng_nxt;
      grp_r <= grp_nxt;
      pos_r <= pos_nxt;
      sub_r <= sub_nxt;
      rep_r <= rep_nxt;
      xv_r <= xv_nxt;
      mult_r <= mult_nxt;
    end
  end

  // Lookup follows the region being entered, so a new region starts with its own group
  assign sequence_select_o = region_sequence_select_i[reg_nxt]; // R02
  assign pattern_select_o = grp_r;
  assign vertical_transfer_outputs_o = xv_r;
  assign region_o = reg_r;
  assign sensor_gate_line_o = on_sg_line;
  assign train_active_o = (eng_r != cvrm_pkg::ENG_IDLE);

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_line_cut_restart: assert property ( // R10
    (ce_i && horizontal_line_sync_i && !sweep_keep) |=> (eng_r == cvrm_pkg::ENG_LOAD))
    else $error("line start did not restart the train");

  a_sweep_no_restart: assert property ( // R09
    (ce_i && horizontal_line_sync_i && !field_start_i && sweep_keep && !sg_hit && !sp_hit)
      |=> $stable(grp_r))
    else $error("sweep region restarted at a line boundary");

  a_first_group_sel: assert property ( // R02
    (ce_i && field_start_i) |=> (grp_r == $past(sequence_group_i)))
    else $error("first group not taken from sequence");

  a_second_group_sel: assert property ( // R03
    (ce_i && !line_start && sg_hit) |=> (grp_r == $past(second_group_select_i)))
    else $error("second group not selected at its start pixel");

  a_special_group_sel: assert property ( // R21
    (ce_i && !line_start && !sg_hit && sp_hit)
      |=> (grp_r == $past(special_pattern_select_i)))
    else $error("special pattern not selected");

  a_special_off: assert property ( // R04
    (ce_i && !special_insert_enable_i && !line_start && !sg_hit) |=> $stable(grp_r))
    else $error("group changed while special insert was disabled");

  a_load_polarity: assert property ( // R16
    (ce_i && eng_r == cvrm_pkg::ENG_LOAD && !start_any)
      |=> (xv_r == $past(pattern_polarity_i)))
    else $error("start polarity not loaded");

  a_mult_hold: assert property ( // R16
    (ce_i && eng_r == cvrm_pkg::ENG_RUN && mult_r && !tick && !start_any) |=> $stable(xv_r))
    else $error("output moved between multiplier steps");

  a_idle_hold: assert property ( // R12
    (ce_i && eng_r == cvrm_pkg::ENG_IDLE && !start_any) ##1 (ce_i && !start_any)
      |=> $stable(xv_r) && (eng_r == cvrm_pkg::ENG_IDLE))
    else $error("outputs moved after the train ended");

  a_ce_freeze: assert property (
    !ce_i |=> $stable(xv_r) && $stable(grp_r) && $stable(eng_r) && $stable(pix_r))
    else $error("state moved while clock enable was low");

  a_pix_restart: assert property ( // R21
    (ce_i && (field_start_i || horizontal_line_sync_i)) |=> (pix_r == cvrm_pkg::PIX_ZERO))
    else $error("pixel count not restarted at line start");

  a_field_region: assert property ( // R21
    (ce_i && field_start_i)
      |=> (reg_r == cvrm_pkg::REG_FIRST) && (lseq_r == cvrm_pkg::LINE_ZERO))
    else $error("field start did not return to the first region");

  a_region_resume: assert property ( // R13
    (ce_i && horizontal_line_sync_i && (reg_nxt != reg_r)) |=> (eng_r == cvrm_pkg::ENG_LOAD))
    else $error("new region did not restart the train");

  a_rep_stop: assert property ( // R12
    (ce_i && eng_r == cvrm_pkg::ENG_RUN && !mult_r && !start_any && (pos_r == len_m1) &&
     (rep_r + cvrm_pkg::REP_STEP == pattern_repeat_count_i)) |=> (eng_r == cvrm_pkg::ENG_IDLE))
    else $error("pulse train did not end after its repeat count");

  a_pos_step: assert property ( // R12
    (ce_i && eng_r == cvrm_pkg::ENG_RUN && !mult_r && !start_any && (pos_r != len_m1))
      |=> (pos_r == $past(pos_r) + cvrm_pkg::PIX_STEP))
    else $error("pattern position did not advance by one pixel");

  a_mult_step: assert property ( // R16
    (ce_i && eng_r == cvrm_pkg::ENG_RUN && mult_r && !start_any && (sub_r != len_m1))
      |=> $stable(pos_r))
    else $error("multiplier position moved inside a counter length");

endmodule : cvrm_vregion

// *** src/cvrm_pkg.sv ***
package cvrm_pkg;
  localparam int LINE_W = 12;
  localparam int PIX_W = 13;
  localparam int SEL_W = 5;
  localparam int REP_W = 12;
  localparam int NUM_XV = 13;
  localparam int NUM_TOG = 6;
  localparam int NUM_REG = 7;
  localparam int REG_W = 3;
  localparam logic [REG_W-1:0] REG_FIRST = 3'h0;
  localparam logic [REG_W-1:0] REG_LAST = 3'h6;
  localparam logic [REG_W-1:0] REG_STEP = 3'h1;
  localparam logic [LINE_W-1:0] LINE_ZERO = 12'h000;
  localparam logic [LINE_W-1:0] LINE_STEP = 12'h001;
  localparam logic [PIX_W-1:0] PIX_ZERO = 13'h0000;
  localparam logic [PIX_W-1:0] PIX_STEP = 13'h0001;
  localparam logic [REP_W-1:0] REP_ZERO = 12'h000;
  localparam logic [REP_W-1:0] REP_STEP = 12'h001;
  localparam logic [SEL_W-1:0] SEL_ZERO = 5'h00;
  localparam logic [NUM_XV-1:0] XV_ZERO = 13'h0000;
  typedef enum logic [1:0] {ENG_IDLE, ENG_LOAD, ENG_RUN} cvrm_eng_t;
endpackage : cvrm_pkg

// *** bench/cvrm_ccd_model.sv ***
`timescale 1ns/1ps
// Sensor side: counts clocks spent with the first vertical phase high
module cvrm_ccd_model (
  input wire logic mclk_i,
  input wire logic clr_i,
  input wire logic [cvrm_pkg::NUM_XV-1:0] vertical_transfer_outputs_i,
  output int high_cnt_o
);
  always_ff @(posedge mclk_i)
  begin
    if (clr_i)
      high_cnt_o <= 0;
    else if (vertical_transfer_outputs_i[0] === 1'b1)
      high_cnt_o <= high_cnt_o + 1;
  end
endmodule : cvrm_ccd_model

// *** bench/tb_ccd_vertical_region_modes.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("mismatch %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module tb_ccd_vertical_region_modes;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hs = 1'b0;
  logic fs = 1'b0;
  logic clr = 1'b0;
  logic [6:0][11:0] rcl = {7{12'hfff}};
  logic [6:0] sweep = 7'h00;
  logic [6:0] multi = 7'h00;
  logic [11:0] gate_line = 12'hfff;
  logic [11:0] rep = 12'h003;
  logic sp_en = 1'b0;
  logic ce = 1'b1;
  logic [11:0] sp_line = 12'h000;
  logic [12:0] len = 13'h0004;
  logic [4:0] seq_sel;
  logic [4:0] pat_sel;
  logic [12:0] xv;
  logic [2:0] region;
  logic sgl;
  logic act;
  logic [12:0][5:0][12:0] tog;
  int high_cnt;
  int fails = 0;
  int checked = 0;

  // Group 2 toggles at pixels 1 and 3; every other group never toggles
  always_comb
  begin
    tog = {78{13'h1fff}};
    for (int i = 0; i < 13; i++)
    begin
      if (pat_sel == 5'h02)
      begin
        tog[i][0] = 13'h0001;
        tog[i][1] = 13'h0003;
      end
    end
  end

  cvrm_vregion dut_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce),
    .horizontal_line_sync_i(hs),
    .field_start_i(fs),
    .region_change_line_i(rcl),
    .region_sweep_i(sweep),
    .region_multi_i(multi),
    .region_sequence_select_i({7{5'h01}}),
    .sensor_gate_line_i(gate_line),
    .second_group_select_i(5'h07),
    .second_group_start_i(13'h0005),
    .sequence_group_i(seq_sel + 5'h01),
    .pattern_repeat_count_i(rep),
    .special_insert_enable_i(sp_en),
    .special_insert_line_i(sp_line),
    .special_pattern_select_i(5'h07),
    .special_pattern_start_i(13'h0003),
    .pattern_polarity_i({13{pat_sel[0]}}),
    .vertical_toggle_position_i(tog),
    .pattern_counter_length_i(len),
    .sequence_select_o(seq_sel),
    .pattern_select_o(pat_sel),
    .vertical_transfer_outputs_o(xv),
    .region_o(region),
    .sensor_gate_line_o(sgl),
    .train_active_o(act)
  );

  cvrm_ccd_model ccd_u (
    .mclk_i(mclk_i),
    .clr_i(clr),
    .vertical_transfer_outputs_i(xv),
    .high_cnt_o(high_cnt)
  );

  task end_sim;
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  task pulse(input bit field);
    if (field)
      fs = 1'b1;
    else
      hs = 1'b1;
    step(1);
    fs = 1'b0;
    hs = 1'b0;
  endtask : pulse

  // Starts a train, adds line syncs every 8 clocks, then lets it finish
  task run(input bit field, input int lines);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    pulse(field);
    repeat (lines)
    begin
      step(7);
      pulse(1'b0);
    end
    step(60);
  endtask : run

  initial
  begin
    forever #50 mclk_i = ~mclk_i;
  end

  initial
  begin
    step(3000);
    fails++;
    end_sim();
  end

  initial
  begin
    step(16);
    rst_n_i = 1'b1;
    `CHK("xv", 13'h0000, xv)
    `CHK("pat", 5'h00, pat_sel)
    `CHK("region", 3'h0, region)
    `CHK("act", 1'b0, act)
    `CHK("seq", 5'h01, seq_sel)
    run(1'b1, 0);
    `CHK("train", 6, high_cnt)
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    pulse(1'b1);
    ce = 1'b0;
    step(20);
    `CHK("freeze", 1'b1, act)
    ce = 1'b1;
    step(60);
    `CHK("thaw", 6, high_cnt)
    rep = 12'h000;
    run(1'b1, 0);
    `CHK("train0", 0, high_cnt)
    rep = 12'h003;
    sweep = 7'h01;
    run(1'b1, 2);
    `CHK("sweep", 6, high_cnt)
    sweep = 7'h00;
    run(1'b1, 2);
    `CHK("cut", 14, high_cnt)
    multi = 7'h01;
    run(1'b0, 0);
    `CHK("multi", 8, high_cnt)
    len = 13'h0002;
    run(1'b0, 0);
    `CHK("multi2", 4, high_cnt)
    len = 13'h0004;
    multi = 7'h00;
    gate_line = 12'h000;
    pulse(1'b1);
    step(1);
    `CHK("first", 5'h02, pat_sel)
    `CHK("gate", 1'b1, sgl)
    step(20);
    `CHK("second", 5'h07, pat_sel)
    `CHK("second_xv", 13'h1fff, xv)
    gate_line = 12'hfff;
    sp_line = 12'h001;
    sp_en = 1'b1;
    pulse(1'b1);
    step(7);
    `CHK("special_l0", 5'h02, pat_sel)
    pulse(1'b0);
    step(20);
    `CHK("special", 5'h07, pat_sel)
    `CHK("special_xv", 13'h1fff, xv)
    sp_en = 1'b0;
    pulse(1'b1);
    step(7);
    pulse(1'b0);
    step(20);
    `CHK("no_special", 5'h02, pat_sel)
    rcl[1] = 12'h002;
    sweep = 7'h01;
    run(1'b1, 2);
    `CHK("resume", 12, high_cnt)
    `CHK("region1", 3'h1, region)
    end_sim();
  end
endmodule : tb_ccd_vertical_region_modes
